/* rtl/dfp_pkg.sv */
// dual function io port: shared constants
// assumes sfr and io ram ports of the mpu on one core clock
package dfp_pkg;
    // ------------------------------------------------------------------
    // sfr addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  SFR_GRP_A_DATA = 8'h80;
    localparam logic [7:0]  SFR_GRP_B_DATA = 8'h90;
    localparam logic [7:0]  SFR_GRP_B_DIR  = 8'h91;
    localparam logic [7:0]  SFR_GRP_C_DATA = 8'ha0;
    localparam logic [7:0]  SFR_GRP_C_DIR  = 8'ha1;
    localparam logic [7:0]  SFR_GRP_A_DIR  = 8'ha2;
    // ------------------------------------------------------------------
    // io ram addresses and fields
    // ------------------------------------------------------------------
    localparam logic [15:0] XR_ROUTE       = 16'h2008;
    localparam logic [15:0] XR_RES_FIRST   = 16'h2009;
    localparam logic [15:0] XR_RES_LAST    = 16'h200e;
    localparam logic [15:0] XR_SEG_COUNT   = 16'h2020;
    localparam int          ROUTE_PW_BIT   = 2;
    localparam int          ROUTE_PV_BIT   = 3;
    localparam int          ROUTE_EE_BIT   = 4;
    localparam int          RES_LO_POS     = 0;
    localparam int          RES_HI_POS     = 4;
    localparam logic [7:0]  DIR_RESET      = 8'h00;
    localparam logic [7:0]  DATA_RESET     = 8'h00;
    localparam logic [4:0]  SEG_RESET      = 5'h00;
    // ------------------------------------------------------------------
    // pin layout: 12 pins, index 0..11 = pins 4..11,14,15,16,17
    // ------------------------------------------------------------------
    localparam int          NPIN           = 12;
    localparam int          NRES_PIN       = 8;
    localparam int          SYNC_STAGES    = 3;
    // resource select codes
    localparam logic [2:0]  RES_NONE       = 3'h0;
    localparam logic [2:0]  RES_T0         = 3'h2;
    localparam logic [2:0]  RES_T1         = 3'h3;
    localparam logic [2:0]  RES_HI_RISE    = 3'h4;
    localparam logic [2:0]  RES_LO_RISE    = 3'h5;
    localparam logic [2:0]  RES_HI_FALL    = 3'h6;
    localparam logic [2:0]  RES_LO_FALL    = 3'h7;
endpackage

/* rtl/dfp_sync_if.sv */
// dual function io port: carrier between top and pin synchroniser
// assumes one core clock
`timescale 1ns/10ps
interface dfp_sync_if;
    import dfp_pkg::*;
    logic [NPIN-1:0] raw;
    logic [NPIN-1:0] level;
    modport top  (output raw, input level);
    modport sync (input raw, output level);
endinterface

/* rtl/dfp_pin_sync.sv */
// dual function io port: three stage pin synchroniser with agreement
// assumes raw pins are asynchronous to the core clock
`timescale 1ns/10ps
module dfp_pin_sync
    import dfp_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    dfp_sync_if.sync  s_if
);
    logic [NPIN-1:0] st1_reg, st2_reg, st3_reg, lvl_reg;
    logic [NPIN-1:0] lvl_next;

    // ------------------------------------------------------------------
    // level changes once stages two and three agree
    // ------------------------------------------------------------------
    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < NPIN; i++) begin
            if (st2_reg[i] == st3_reg[i]) begin
                lvl_next[i] = st3_reg[i];
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st1_reg <= '0;
            st2_reg <= '0;
            st3_reg <= '0;
            lvl_reg <= '0;
        end else begin
            st1_reg <= s_if.raw;
            st2_reg <= st1_reg;
            st3_reg <= st2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign s_if.level = lvl_reg;
endmodule

/* rtl/dfp_port.sv */
// dual function io port: direction, data latches, lcd handover, resource routing
// assumes sfr port and io ram port of the mpu, single core clock
`timescale 1ns/10ps
module dfp_port
    import dfp_pkg::*;
(
    input  wire logic            i_core_clk,
    input  wire logic            i_rst,
    input  wire logic [7:0]      i_sfr_addr,
    input  wire logic            i_sfr_wr,
    input  wire logic            i_sfr_rd,
    input  wire logic [7:0]      i_sfr_wdata,
    output logic      [7:0]      o_sfr_rdata,
    input  wire logic [15:0]     i_xr_addr,
    input  wire logic            i_xr_wr,
    input  wire logic            i_xr_rd,
    input  wire logic [7:0]      i_xr_wdata,
    output logic      [7:0]      o_xr_rdata,
    input  wire logic [NPIN-1:0] i_general_pin,
    output logic      [NPIN-1:0] o_general_pin,
    output logic      [NPIN-1:0] o_general_pin_oe,
    output logic      [NPIN-1:0] o_segment_pin_sel,
    input  wire logic            i_energy_pulse_out,
    input  wire logic            i_reactive_pulse_out,
    input  wire logic            i_ee_clk_out,
    input  wire logic            i_ee_data_out,
    input  wire logic            i_ee_data_oe,
    output logic                 o_ee_data_in,
    output logic                 o_counter_zero_clock_in,
    output logic                 o_counter_one_clock_in,
    output logic                 o_high_priority_pin_irq,
    output logic                 o_low_priority_pin_irq
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  dir_a_reg, dir_b_reg, dir_c_reg, dat_a_reg, dat_b_reg, dat_c_reg;
    logic [7:0]  dir_a_next, dir_b_next, dir_c_next, dat_a_next, dat_b_next, dat_c_next;
    logic [7:0]  route_reg, route_next;
    logic [4:0]  seg_reg, seg_next;
    logic [2:0]  res_reg [NRES_PIN];
    logic [2:0]  res_next [NRES_PIN];
    logic [7:0]  sfr_rdata_reg, sfr_rdata_next, xr_rdata_reg, xr_rdata_next;

    logic [NPIN-1:0] dir_vec, dat_vec, lvl, out_next, oe_next, seg_next_sel;
    logic [NPIN-1:0] out_reg, oe_reg, seg_sel_reg;
    logic [NPIN-1:0] rd_vec;
    logic [3:0]      res_sig_next, res_sig_reg;
    logic            ee_in_reg;

    dfp_sync_if s_if ();
    assign s_if.raw = i_general_pin;
    assign lvl      = s_if.level;

    dfp_pin_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .s_if       (s_if)
    );

    // ------------------------------------------------------------------
    // pin vectors from group registers
    // ------------------------------------------------------------------
    // direction bit placement
    assign dir_vec = {dir_c_reg[1:0], dir_b_reg[7:6], dir_b_reg[3:0], dir_a_reg[7:4]};
    assign dat_vec = {dat_c_reg[1:0], dat_b_reg[7:6], dat_b_reg[3:0], dat_a_reg[7:4]};

    // output pins read latch, inputs read level
    assign rd_vec = (dir_vec & dat_vec) | (~dir_vec & lvl);

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always_comb begin
        dir_a_next = dir_a_reg;
        dir_b_next = dir_b_reg;
        dir_c_next = dir_c_reg;
        dat_a_next = dat_a_reg;
        dat_b_next = dat_b_reg;
        dat_c_next = dat_c_reg;
        route_next = route_reg;
        seg_next   = seg_reg;
        res_next   = res_reg;
        if (i_sfr_wr) begin
            unique case (i_sfr_addr)
                SFR_GRP_A_DIR:  dir_a_next = i_sfr_wdata;
                SFR_GRP_B_DIR:  dir_b_next = i_sfr_wdata;
                SFR_GRP_C_DIR:  dir_c_next = i_sfr_wdata;
                SFR_GRP_A_DATA: dat_a_next = i_sfr_wdata;
                SFR_GRP_B_DATA: dat_b_next = i_sfr_wdata;
                SFR_GRP_C_DATA: dat_c_next = i_sfr_wdata;
                default: ;
            endcase
        end
        if (i_xr_wr) begin
            if (i_xr_addr == XR_ROUTE) begin
                route_next = i_xr_wdata;
            end
            if (i_xr_addr == XR_SEG_COUNT) begin
                seg_next = i_xr_wdata[4:0];
            end
            for (int k = 0; k < NRES_PIN / 2; k++) begin
                if (i_xr_addr == XR_RES_FIRST + 16'(k)) begin
                    res_next[2*k]   = i_xr_wdata[RES_LO_POS +: 3];
                    res_next[2*k+1] = i_xr_wdata[RES_HI_POS +: 3];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        sfr_rdata_next = sfr_rdata_reg;
        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                SFR_GRP_A_DIR:  sfr_rdata_next = dir_a_reg;
                SFR_GRP_B_DIR:  sfr_rdata_next = dir_b_reg;
                SFR_GRP_C_DIR:  sfr_rdata_next = dir_c_reg;
                SFR_GRP_A_DATA: sfr_rdata_next = {rd_vec[3:0], dat_a_reg[3:0]};
                SFR_GRP_B_DATA: sfr_rdata_next = {rd_vec[9:8], dat_b_reg[5:4], rd_vec[7:4]};
                SFR_GRP_C_DATA: sfr_rdata_next = {dat_c_reg[7:2], rd_vec[11:10]};
                default:        sfr_rdata_next = 8'h00;
            endcase
        end
        xr_rdata_next = xr_rdata_reg;
        if (i_xr_rd) begin
            xr_rdata_next = 8'h00;
            if (i_xr_addr == XR_ROUTE) begin
                xr_rdata_next = route_reg;
            end
            if (i_xr_addr == XR_SEG_COUNT) begin
                xr_rdata_next = {3'h0, seg_reg};
            end
            for (int k = 0; k < NRES_PIN / 2; k++) begin
                if (i_xr_addr == XR_RES_FIRST + 16'(k)) begin
                    xr_rdata_next = {1'b0, res_reg[2*k+1], 1'b0, res_reg[2*k]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            seg_next_sel[i] = (5'(NPIN - i) <= seg_reg);
        end
        out_next = dat_vec;
        oe_next  = dir_vec;
        // pulse outputs on pins 6 and 7
        if (dir_vec[2] && route_reg[ROUTE_PW_BIT]) begin
            out_next[2] = i_energy_pulse_out;
        end
        if (dir_vec[3] && route_reg[ROUTE_PV_BIT]) begin
            out_next[3] = i_reactive_pulse_out;
        end
        // eeprom clock on pin 4, data on pin 5
        if (route_reg[ROUTE_EE_BIT]) begin
            out_next[0] = i_ee_clk_out;
            oe_next[0]  = 1'b1;
            out_next[1] = i_ee_data_out;
            oe_next[1]  = i_ee_data_oe;
        end
        oe_next  = oe_next & ~seg_next_sel;
    end

    // ------------------------------------------------------------------
    // resource routing
    // ------------------------------------------------------------------
    always_comb begin
        res_sig_next = 4'h0;
        for (int i = 0; i < NRES_PIN; i++) begin
            if (!seg_sel_reg[i]) begin
                unique case (res_reg[i])
                    RES_T0:      res_sig_next[0] = res_sig_next[0] | lvl[i];
                    RES_T1:      res_sig_next[1] = res_sig_next[1] | lvl[i];
                    RES_HI_RISE: res_sig_next[2] = res_sig_next[2] | lvl[i];
                    RES_LO_RISE: res_sig_next[3] = res_sig_next[3] | lvl[i];
                    RES_HI_FALL: res_sig_next[2] = res_sig_next[2] | ~lvl[i];
                    RES_LO_FALL: res_sig_next[3] = res_sig_next[3] | ~lvl[i];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_a_reg     <= DIR_RESET;
            dir_b_reg     <= DIR_RESET;
            dir_c_reg     <= DIR_RESET;
            dat_a_reg     <= DATA_RESET;
            dat_b_reg     <= DATA_RESET;
            dat_c_reg     <= DATA_RESET;
            route_reg     <= 8'h00;
            seg_reg       <= SEG_RESET;
            for (int k = 0; k < NRES_PIN; k++) begin
                res_reg[k] <= RES_NONE;
            end
            sfr_rdata_reg <= 8'h00;
            xr_rdata_reg  <= 8'h00;
            out_reg       <= '0;
            oe_reg        <= '0;
            seg_sel_reg   <= '0;
            res_sig_reg   <= 4'h0;
            ee_in_reg     <= 1'b0;
        end else begin
            dir_a_reg     <= dir_a_next;
            dir_b_reg     <= dir_b_next;
            dir_c_reg     <= dir_c_next;
            dat_a_reg     <= dat_a_next;
            dat_b_reg     <= dat_b_next;
            dat_c_reg     <= dat_c_next;
            route_reg     <= route_next;
            seg_reg       <= seg_next;
            res_reg       <= res_next;
            sfr_rdata_reg <= sfr_rdata_next;
            xr_rdata_reg  <= xr_rdata_next;
            out_reg       <= out_next;
            oe_reg        <= oe_next;
            seg_sel_reg   <= seg_next_sel;
            res_sig_reg   <= res_sig_next;
            ee_in_reg     <= lvl[1];
        end
    end

    assign o_sfr_rdata             = sfr_rdata_reg;
    assign o_xr_rdata              = xr_rdata_reg;
    assign o_general_pin           = out_reg;
    assign o_general_pin_oe        = oe_reg;
    assign o_segment_pin_sel       = seg_sel_reg;
    assign o_ee_data_in            = ee_in_reg;
    assign o_counter_zero_clock_in = res_sig_reg[0];
    assign o_counter_one_clock_in  = res_sig_reg[1];
    assign o_high_priority_pin_irq = res_sig_reg[2];
    assign o_low_priority_pin_irq  = res_sig_reg[3];
endmodule

/* test/dfp_port_properties.sv */
// dual function io port: port checker
// assumes a bind onto dfp_port, one core clock
`timescale 1ns/10ps
module dfp_port_properties
    import dfp_pkg::*;
(
    input wire logic            i_core_clk,
    input wire logic            i_rst,
    input wire logic [7:0]      i_sfr_addr,
    input wire logic            i_sfr_wr,
    input wire logic [7:0]      i_sfr_wdata,
    input wire logic [15:0]     i_xr_addr,
    input wire logic            i_xr_wr,
    input wire logic [7:0]      i_xr_wdata,
    input wire logic [NPIN-1:0] i_general_pin,
    input wire logic [NPIN-1:0] o_general_pin,
    input wire logic [NPIN-1:0] o_general_pin_oe,
    input wire logic [NPIN-1:0] o_segment_pin_sel,
    input wire logic            i_energy_pulse_out,
    input wire logic            o_counter_zero_clock_in
);
    logic [7:0]  t0_reg;
    logic [4:0]  seg_reg;
    logic [7:0]  route_reg;
    logic [11:0] seg_mask;
    logic [5:0]  dir_b_wd;
    // --------
    // shadow of io ram settings
    // --------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            t0_reg    <= 8'h00;
            seg_reg   <= 5'h00;
            route_reg <= 8'h00;
        end else if (i_xr_wr) begin
            for (int k = 0; k < 4; k++) begin
                if (i_xr_addr == XR_RES_FIRST + 16'(k)) begin
                    t0_reg[2*k]   <= i_xr_wdata[2:0] == RES_T0;
                    t0_reg[2*k+1] <= i_xr_wdata[6:4] == RES_T0;
                end
            end
            if (i_xr_addr == XR_SEG_COUNT) seg_reg <= i_xr_wdata[4:0];
            if (i_xr_addr == XR_ROUTE) route_reg <= i_xr_wdata;
        end
    end
    assign seg_mask = (seg_reg >= 5'h0c) ? 12'hfff : ~(12'hfff >> seg_reg);
    assign dir_b_wd = {i_sfr_wdata[7:6], i_sfr_wdata[3:0]};
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_rst_in; $fell(i_rst) |-> o_general_pin_oe == 12'h000; endproperty
    a_rst_in: assert property (p_rst_in) else $error("pins drive after reset");
    property p_seg_map; $stable(seg_reg) [*3] |-> o_segment_pin_sel == seg_mask; endproperty
    a_seg_map: assert property (p_seg_map) else $error("segment pins wrong");
    property p_dir_b; i_sfr_wr && i_sfr_addr == SFR_GRP_B_DIR |-> ##2
        o_general_pin_oe[9:4] == ($past(dir_b_wd, 2) & ~o_segment_pin_sel[9:4]); endproperty
    a_dir_b: assert property (p_dir_b) else $error("group b direction wrong");
    property p_latch_c; i_sfr_wr && i_sfr_addr == SFR_GRP_C_DATA ##2 o_general_pin_oe[11]
        |-> o_general_pin[11] == $past(i_sfr_wdata[1], 2); endproperty
    a_latch_c: assert property (p_latch_c) else $error("output pin not latch");
    property p_no_t0; (t0_reg == 8'h00) [*8] |-> !o_counter_zero_clock_in; endproperty
    a_no_t0: assert property (p_no_t0) else $error("counter clock unselected");
    property p_t0_or; (|(t0_reg & i_general_pin[7:0] & ~o_segment_pin_sel[7:0])) [*8]
        |-> o_counter_zero_clock_in; endproperty
    a_t0_or: assert property (p_t0_or) else $error("counter clock not or");
    property p_pulse; route_reg[ROUTE_PW_BIT] [*3] ##0 o_general_pin_oe[2]
        |-> o_general_pin[2] == $past(i_energy_pulse_out); endproperty
    a_pulse: assert property (p_pulse) else $error("energy pulse not on pin");
    property p_ee_clk; route_reg[ROUTE_EE_BIT] [*3] ##0 !o_segment_pin_sel[0]
        |-> o_general_pin_oe[0]; endproperty
    a_ee_clk: assert property (p_ee_clk) else $error("eeprom clock not driven");
endmodule

/* test/dfp_pin_board.sv */
// dual function io port: board side of the twelve shared pins
// assumes a pin shows the port drive, else lcd waveform, else board level
`timescale 1ns/10ps
module dfp_pin_board
    import dfp_pkg::*;
(
    input  wire logic            i_core_clk,
    input  wire logic [NPIN-1:0] i_drive,
    input  wire logic [NPIN-1:0] i_drive_oe,
    input  wire logic [NPIN-1:0] i_segment_sel,
    input  wire logic [NPIN-1:0] i_board_level,
    output logic      [NPIN-1:0] o_pin
);
    logic [NPIN-1:0] lcd_reg = 12'h5a5;
    // lcd segment waveform, never steady
    always_ff @(posedge i_core_clk) begin
        lcd_reg <= ~lcd_reg;
    end
    assign o_pin = (i_drive_oe & i_drive) | (~i_drive_oe & i_segment_sel & lcd_reg)
                 | (~i_drive_oe & ~i_segment_sel & i_board_level);
endmodule

/* test/dfp_port_tb.sv */
// dual function io port: self-checking bench
// assumes package, port, checker and board model compiled first
`timescale 1ns/10ps
module dfp_port_tb;
    import dfp_pkg::*;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_xr_wr = 1'b0, i_xr_rd = 1'b0;
    logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_xr_wdata = 8'h00, o_sfr_rdata, o_xr_rdata, rd_val;
    logic [15:0] i_xr_addr = 16'h0000;
    logic [11:0] i_general_pin, o_general_pin, o_general_pin_oe, o_segment_pin_sel, lvl = 12'h000;
    logic i_energy_pulse_out = 1'b0, i_reactive_pulse_out = 1'b0, i_ee_clk_out = 1'b0;
    logic i_ee_data_out = 1'b0, i_ee_data_oe = 1'b0, o_ee_data_in;
    logic o_counter_zero_clock_in, o_counter_one_clock_in, o_high_priority_pin_irq, o_low_priority_pin_irq;
    logic [7:0]  dirs [3] = '{SFR_GRP_A_DIR, SFR_GRP_B_DIR, SFR_GRP_C_DIR};
    logic [7:0]  dats [3] = '{SFR_GRP_A_DATA, SFR_GRP_B_DATA, SFR_GRP_C_DATA};
    logic [7:0]  dvals [3] = '{8'h50, 8'h85, 8'h02};
    logic [7:0]  rvals [2][3] = '{'{8'h50, 8'hb5, 8'h02}, '{8'hf0, 8'hff, 8'h03}};
    logic [4:0]  segs [5] = '{5'h00, 5'h01, 5'h07, 5'h0c, 5'h1f};
    int n_mismatch = 0, num_checks = 0, cycles = 0;
    always #5 i_core_clk = ~i_core_clk;
    dfp_port dut (.*);
    dfp_pin_board u_board (.i_core_clk(i_core_clk), .i_drive(o_general_pin), .i_drive_oe(o_general_pin_oe),
        .i_segment_sel(o_segment_pin_sel), .i_board_level(lvl), .o_pin(i_general_pin));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic xr, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_sfr_addr <= a[7:0];
        i_xr_addr <= a;
        i_sfr_wdata <= d;
        i_xr_wdata <= d;
        {i_xr_wr, i_xr_rd, i_sfr_wr, i_sfr_rd} <= {xr & wr, xr & !wr, !xr & wr, !xr & !wr};
        @(posedge i_core_clk);
        {i_xr_wr, i_xr_rd, i_sfr_wr, i_sfr_rd} <= 4'h0;
        #1 rd_val = xr ? o_xr_rdata : o_sfr_rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic t_regs;
        chk(o_general_pin_oe, 12'h000, "oe after reset");
        for (int i = 0; i < 3; i++) begin
            acc(1'b0, 1'b0, 16'(dirs[i]), 8'h00);
            chk(12'(rd_val), 12'h000, "direction reset");
            acc(1'b0, 1'b1, 16'(dirs[i]), dvals[i]);
        end
        settle(2);
        chk(o_general_pin_oe, 12'ha55, "pin directions");
        for (int i = 0; i < 3; i++) begin
            acc(1'b0, 1'b0, 16'(dirs[i]), 8'h00);
            chk(12'(rd_val), 12'(dvals[i]), "direction readback");
        end
        acc(1'b0, 1'b0, 16'h0081, 8'h00);
        chk(12'(rd_val), 12'h000, "unmapped sfr");
        acc(1'b1, 1'b0, 16'h2030, 8'h00);
        chk(12'(rd_val), 12'h000, "unmapped io ram");
        $display("test registers done");
    endtask
    task automatic t_data;
        acc(1'b0, 1'b1, 16'(SFR_GRP_A_DATA), 8'hf0);
        acc(1'b0, 1'b1, 16'(SFR_GRP_B_DATA), 8'hff);
        acc(1'b0, 1'b1, 16'(SFR_GRP_C_DATA), 8'h03);
        for (int l = 0; l < 2; l++) begin
            @(posedge i_core_clk);
            lvl <= l ? 12'hfff : 12'h000;
            settle(6);
            chk(o_general_pin & o_general_pin_oe, 12'ha55, "driven pins");
            for (int i = 0; i < 3; i++) begin
                acc(1'b0, 1'b0, 16'(dats[i]), 8'h00);
                chk(12'(rd_val), 12'(rvals[l][i]), "data read");
            end
        end
        $display("test data done");
    endtask
    task automatic t_segment;
        logic [11:0] m;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 1'b1, XR_SEG_COUNT, 8'(segs[i]));
            settle(2);
            m = (segs[i] >= 5'h0c) ? 12'hfff : ~(12'hfff >> segs[i]);
            chk(o_segment_pin_sel, m, "segment pins");
            chk(o_segment_pin_sel & o_general_pin_oe, 12'h000, "segment pin driven");
            acc(1'b1, 1'b0, XR_SEG_COUNT, 8'h00);
            chk(12'(rd_val[4:0]), 12'(segs[i]), "segment count readback");
        end
        acc(1'b1, 1'b1, XR_SEG_COUNT, 8'h00);
        $display("test segment done");
    endtask
    task automatic t_resource;
        logic [3:0] e;
        acc(1'b0, 1'b1, 16'(SFR_GRP_A_DIR), 8'h00);
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, 1'b1, XR_RES_FIRST, 8'(c));
            for (int l = 0; l < 2; l++) begin
                @(posedge i_core_clk);
                lvl <= 12'(l);
                settle(8);
                e = {c == 2 && l == 1, c == 3 && l == 1, (c == 4 && l == 1) || (c == 6 && l == 0),
                     (c == 5 && l == 1) || (c == 7 && l == 0)};
                chk(12'({o_counter_zero_clock_in, o_counter_one_clock_in, o_high_priority_pin_irq,
                    o_low_priority_pin_irq}), 12'(e), "resource code");
            end
        end
        acc(1'b1, 1'b1, XR_RES_FIRST, 8'h22);
        @(posedge i_core_clk);
        lvl <= 12'h002;
        settle(8);
        chk(12'(o_counter_zero_clock_in), 12'h001, "shared resource");
        acc(1'b0, 1'b1, 16'(SFR_GRP_A_DATA), 8'h10);
        acc(1'b0, 1'b1, 16'(SFR_GRP_A_DIR), 8'h10);
        @(posedge i_core_clk);
        lvl <= 12'h000;
        settle(8);
        chk(12'(o_counter_zero_clock_in), 12'h001, "output pin tracked");
        acc(1'b1, 1'b1, XR_RES_FIRST, 8'h00);
        $display("test resource done");
    endtask
    task automatic t_route;
        acc(1'b0, 1'b1, 16'(SFR_GRP_A_DIR), 8'hc0);
        acc(1'b1, 1'b1, XR_ROUTE, 8'h0c);
        for (int p = 0; p < 2; p++) begin
            @(posedge i_core_clk);
            i_energy_pulse_out <= p[0];
            i_reactive_pulse_out <= !p[0];
            settle(3);
            chk(12'(o_general_pin[3:2]), 12'({!p[0], p[0]}), "pulse pins");
        end
        acc(1'b1, 1'b1, XR_ROUTE, 8'h10);
        @(posedge i_core_clk);
        i_ee_clk_out <= 1'b1;
        lvl <= 12'h002;
        settle(6);
        chk(12'({o_general_pin_oe[0], o_general_pin[0], o_ee_data_in}), 12'h007, "eeprom clock, data in");
        @(posedge i_core_clk);
        i_ee_data_oe <= 1'b1;
        settle(8);
        chk(12'({o_general_pin_oe[1], o_general_pin[1], o_ee_data_in}), 12'h004, "eeprom data out");
        $display("test route done");
    endtask
    task automatic t_reset;
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        settle(2);
        chk(o_general_pin_oe, 12'h000, "oe during second reset");
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        settle(1);
        chk(o_general_pin_oe, 12'h000, "oe after second reset");
        acc(1'b0, 1'b0, 16'(SFR_GRP_A_DIR), 8'h00);
        chk(12'(rd_val), 12'h000, "direction after second reset");
        $display("test reset done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("MISMATCH at %0t: timeout", $time);
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        settle(1);
        t_regs();
        t_data();
        t_segment();
        t_resource();
        t_route();
        t_reset();
        complete_run();
    end
endmodule
bind dfp_port dfp_port_properties u_props (.*);
